// ### milcd_pkg.sv
// shared types and constants of the instruction length and cycle decoder
package milcd_pkg;

  // core clocks in one unstretched machine cycle
  localparam int unsigned CLKS_PER_MCYCLE = 4;
  localparam logic [1:0]  PHASE_LAST      = 2'(CLKS_PER_MCYCLE - 1);

  // encoded lengths in bytes and times in machine cycles
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [1:0] CYC_1 = 2'h1;
  localparam logic [1:0] CYC_2 = 2'h2;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE  = 8'h01;

  // operation groups handed over by the fetch logic
  typedef enum logic [5:0] {
    OP_NOP, OP_XOR, OP_AND, OP_OR, OP_ZERO, OP_INVERT, OP_BITSET,
    OP_ROTL, OP_ROTLC, OP_ROTR, OP_ROTRC, OP_TRANSFER, OP_CODEREAD,
    OP_EXTMOVE, OP_PUSH, OP_POP, OP_SWAPACC, OP_NIBSWAP,
    OP_BRCARRYSET, OP_BRCARRYCLEAR, OP_BRBITSET, OP_BRBITCLEAR,
    OP_BRBITSETCLEAR, OP_PAGECALL, OP_LONGCALL, OP_SUBEXIT, OP_INTEXIT,
    OP_PAGEJUMP, OP_LONGJUMP, OP_SHORTJUMP, OP_INDJUMP, OP_BRZERO,
    OP_BRNONZERO, OP_CMPBRANCH, OP_COUNTDOWN
  } milcd_op_t;

  // operand forms for destination and source
  typedef enum logic [3:0] {
    ND_NONE, ND_RESULT, ND_BANK, ND_DIRECT, ND_INDIRECT, ND_IMM, ND_IMM16,
    ND_CARRY, ND_BIT, ND_NBIT, ND_DPOINTER, ND_EXT8, ND_EXT16, ND_CODEDP,
    ND_CODEPC
  } milcd_opnd_t;

  typedef struct packed {
    milcd_op_t   op;
    milcd_opnd_t dst;
    milcd_opnd_t src;
  } milcd_insn_t;

  typedef struct packed {
    logic [1:0]  len;
    logic [1:0]  cycles;
    logic        illegal;
    logic        branch;
    logic [15:0] offset;
    logic [7:0]  data;
    logic        carry;
    logic        bitVal;
    logic        bitWrite;
  } milcd_result_t;

endpackage

// ### milcd_core.sv
// instruction length, cycle and effect decoder with machine-cycle sequencer
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// [RULE1] xor to result 1 cycle; imm-to-direct 3B/2C
// [RULE2] result unary ops and rotates: 1B/1C
// [RULE3] transfer into result always one cycle
// [RULE4] into bank: 1B1C, 2B2C, 2B1C by source
// [RULE5] into direct: 2B1C, 2B2C or 3B2C
// [RULE6] into indirect: 1B1C, 2B2C, 2B1C by source
// [RULE7] load data pointer constant: 3B/2C
// [RULE8] code byte reads: 1B/2C, two bases
// [RULE9] external moves both ways: 1B/2C
// [RULE10] push and pop direct: 2B/2C
// [RULE11] swaps one cycle; nibble swap low digit
// [RULE12] bit or inverted bit into carry: 2B/2C
// [RULE13] bit to carry 2B1C; carry to bit 2B2C
// [RULE14] carry branches: 2B/2C on carry state
// [RULE15] bit branches: 3B/2C on bit state
// [RULE16] bit-set branch clears bit: 3B/2C
// [RULE17] indirect jump result plus pointer: 1B/2C
// [RULE18] zero tests of result: 2B/2C
// [RULE19] compare branches on inequality: 3B/2C
// [RULE20] count down, branch nonzero: 2B or 3B
// [RULE21] machine cycle is four clocks, stall stretches
// [RULE22] relative offset is signed eight-bit
// [RULE23] calls, jumps, exits take two cycles
// [RULE24] clear, set, invert carry/bit one cycle
module milcd_core
  import milcd_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          insnValid,
  input  wire milcd_insn_t   insn,
  input  wire logic [7:0]    leftByte,
  input  wire logic [7:0]    rightByte,
  input  wire logic [7:0]    relByte,
  input  wire logic          carryFlag,
  input  wire logic          testBit,
  input  wire logic          cycleStall,
  output var  logic          busy_q,
  output var  logic          done_q,
  output var  logic [1:0]    phase_q,
  output var  logic [1:0]    mcycle_q,
  output var  milcd_result_t result_q
);

  logic          take;
  logic          lastClk;
  logic [1:0]    lenD;
  logic [1:0]    cycD;
  logic          legalD;
  milcd_result_t result_d;
  milcd_op_t     op;
  milcd_opnd_t   dst;
  milcd_opnd_t   src;

  assign op      = insn.op;
  assign dst     = insn.dst;
  assign src     = insn.src;
  assign take    = insnValid && !busy_q;
  assign lastClk = busy_q && !cycleStall && (phase_q == PHASE_LAST);

  // length and machine-cycle decode
  always_comb begin
    lenD   = LEN_1;
    cycD   = CYC_1;
    legalD = 1'b0;
    unique case (op)
      OP_NOP: legalD = (dst == ND_NONE);
      OP_XOR, OP_AND, OP_OR: begin
        if (dst == ND_RESULT) begin // see [RULE1]
          legalD = src inside {ND_BANK, ND_DIRECT, ND_INDIRECT, ND_IMM};
          lenD   = (src inside {ND_DIRECT, ND_IMM}) ? LEN_2 : LEN_1;
        end else if (dst == ND_DIRECT) begin // see [RULE1]
          legalD = src inside {ND_RESULT, ND_IMM};
          lenD   = (src == ND_IMM) ? LEN_3 : LEN_2;
          cycD   = (src == ND_IMM) ? CYC_2 : CYC_1;
        end else if (dst == ND_CARRY && op != OP_XOR) begin // see [RULE12]
          legalD = src inside {ND_BIT, ND_NBIT};
          lenD   = LEN_2;
          cycD   = CYC_2;
        end
      end
      OP_ZERO, OP_INVERT, OP_BITSET: begin // see [RULE2] [RULE24]
        legalD = (dst == ND_CARRY) || (dst == ND_BIT) ||
                 (dst == ND_RESULT && op != OP_BITSET);
        lenD   = (dst == ND_BIT) ? LEN_2 : LEN_1;
      end
      OP_ROTL, OP_ROTLC, OP_ROTR, OP_ROTRC: legalD = (dst == ND_RESULT); // see [RULE2]
      OP_TRANSFER: begin
        unique case (dst)
          ND_RESULT: begin // see [RULE3]
            legalD = src inside {ND_BANK, ND_DIRECT, ND_INDIRECT, ND_IMM};
            lenD   = (src inside {ND_DIRECT, ND_IMM}) ? LEN_2 : LEN_1;
          end
          ND_BANK, ND_INDIRECT: begin // see [RULE4] [RULE6]
            legalD = src inside {ND_RESULT, ND_DIRECT, ND_IMM};
            lenD   = (src == ND_RESULT) ? LEN_1 : LEN_2;
            cycD   = (src == ND_DIRECT) ? CYC_2 : CYC_1;
          end
          ND_DIRECT: begin // see [RULE5]
            legalD = src inside {ND_RESULT, ND_BANK, ND_INDIRECT, ND_DIRECT, ND_IMM};
            lenD   = (src inside {ND_DIRECT, ND_IMM}) ? LEN_3 : LEN_2;
            cycD   = (src == ND_RESULT) ? CYC_1 : CYC_2;
          end
          ND_DPOINTER: begin // see [RULE7]
            legalD = (src == ND_IMM16);
            lenD   = LEN_3;
            cycD   = CYC_2;
          end
          ND_CARRY: begin // see [RULE13]
            legalD = (src == ND_BIT);
            lenD   = LEN_2;
          end
          ND_BIT: begin // see [RULE13]
            legalD = (src == ND_CARRY);
            lenD   = LEN_2;
            cycD   = CYC_2;
          end
          default: legalD = 1'b0;
        endcase
      end
      OP_CODEREAD: begin // see [RULE8]
        legalD = (dst == ND_RESULT) && (src inside {ND_CODEDP, ND_CODEPC});
        cycD   = CYC_2;
      end
      OP_EXTMOVE: begin // see [RULE9]
        legalD = (dst == ND_RESULT && src inside {ND_EXT8, ND_EXT16}) ||
                 (src == ND_RESULT && dst inside {ND_EXT8, ND_EXT16});
        cycD   = CYC_2;
      end
      OP_PUSH, OP_POP: begin // see [RULE10]
        legalD = (dst == ND_DIRECT);
        lenD   = LEN_2;
        cycD   = CYC_2;
      end
      OP_SWAPACC: begin // see [RULE11]
        legalD = (dst == ND_RESULT) && (src inside {ND_BANK, ND_DIRECT, ND_INDIRECT});
        lenD   = (src == ND_DIRECT) ? LEN_2 : LEN_1;
      end
      OP_NIBSWAP: legalD = (dst == ND_RESULT) && (src == ND_INDIRECT); // see [RULE11]
      OP_BRCARRYSET, OP_BRCARRYCLEAR, OP_BRZERO, OP_BRNONZERO, OP_PAGECALL,
      OP_PAGEJUMP, OP_SHORTJUMP: begin // see [RULE14] [RULE18] [RULE23]
        legalD = 1'b1;
        lenD   = LEN_2;
        cycD   = CYC_2;
      end
      OP_BRBITSET, OP_BRBITCLEAR, OP_BRBITSETCLEAR, OP_LONGCALL,
      OP_LONGJUMP: begin // see [RULE15] [RULE16] [RULE23]
        legalD = 1'b1;
        lenD   = LEN_3;
        cycD   = CYC_2;
      end
      OP_SUBEXIT, OP_INTEXIT, OP_INDJUMP: begin // see [RULE17] [RULE23]
        legalD = 1'b1;
        cycD   = CYC_2;
      end
      OP_CMPBRANCH: begin // see [RULE19]
        legalD = (dst == ND_RESULT && src inside {ND_DIRECT, ND_IMM}) ||
                 (dst inside {ND_BANK, ND_INDIRECT} && src == ND_IMM);
        lenD   = LEN_3;
        cycD   = CYC_2;
      end
      OP_COUNTDOWN: begin // see [RULE20]
        legalD = dst inside {ND_BANK, ND_DIRECT};
        lenD   = (dst == ND_DIRECT) ? LEN_3 : LEN_2;
        cycD   = CYC_2;
      end
      default: legalD = 1'b0;
    endcase
    // an unknown form is consumed as one byte, one cycle, with no effect
    if (!legalD) begin
      lenD = LEN_1;
      cycD = CYC_1;
    end
  end

  // operation effects
  always_comb begin
    result_d          = '0;
    result_d.len      = lenD;
    result_d.cycles   = cycD;
    result_d.illegal  = !legalD;
    result_d.offset   = {{8{relByte[7]}}, relByte}; // see [RULE22]
    result_d.data     = leftByte;
    result_d.carry    = carryFlag;
    result_d.bitVal   = testBit;
    unique case (op)
      OP_XOR: result_d.data = leftByte ^ rightByte; // see [RULE1]
      OP_AND, OP_OR: begin
        if (dst == ND_CARRY) begin // see [RULE12]
          result_d.carry = (op == OP_AND) ?
            (carryFlag & (testBit ^ (src == ND_NBIT))) :
            (carryFlag | (testBit ^ (src == ND_NBIT)));
        end else begin
          result_d.data = (op == OP_AND) ? (leftByte & rightByte) : (leftByte | rightByte);
        end
      end
      OP_ZERO, OP_INVERT, OP_BITSET: begin // see [RULE2] [RULE24]
        result_d.data     = (op == OP_ZERO) ? BYTE_ZERO : ~leftByte;
        result_d.carry    = (op == OP_BITSET) || (op == OP_INVERT && !carryFlag);
        result_d.bitVal   = (op == OP_BITSET) || (op == OP_INVERT && !testBit);
        result_d.bitWrite = (dst == ND_BIT);
      end
      OP_ROTL:  result_d.data = {leftByte[6:0], leftByte[7]}; // see [RULE2]
      OP_ROTR:  result_d.data = {leftByte[0], leftByte[7:1]};
      OP_ROTLC: begin // see [RULE2]
        result_d.data  = {leftByte[6:0], carryFlag};
        result_d.carry = leftByte[7];
      end
      OP_ROTRC: begin // see [RULE2]
        result_d.data  = {carryFlag, leftByte[7:1]};
        result_d.carry = leftByte[0];
      end
      OP_TRANSFER: begin
        result_d.data     = rightByte; // see [RULE3]
        result_d.carry    = (dst == ND_CARRY) ? testBit : carryFlag; // see [RULE13]
        result_d.bitVal   = carryFlag;
        result_d.bitWrite = (dst == ND_BIT);
      end
      OP_SWAPACC: result_d.data = rightByte; // see [RULE11]
      OP_NIBSWAP: result_d.data = {leftByte[7:4], rightByte[3:0]}; // see [RULE11]
      OP_BRCARRYSET:   result_d.branch = carryFlag; // see [RULE14]
      OP_BRCARRYCLEAR: result_d.branch = !carryFlag;
      OP_BRBITSET:     result_d.branch = testBit; // see [RULE15]
      OP_BRBITCLEAR:   result_d.branch = !testBit;
      OP_BRBITSETCLEAR: begin // see [RULE16]
        result_d.branch   = testBit;
        result_d.bitVal   = 1'b0;
        result_d.bitWrite = testBit;
      end
      OP_BRZERO:    result_d.branch = (leftByte == BYTE_ZERO); // see [RULE18]
      OP_BRNONZERO: result_d.branch = (leftByte != BYTE_ZERO);
      OP_CMPBRANCH: result_d.branch = (leftByte != rightByte); // see [RULE19]
      OP_COUNTDOWN: begin // see [RULE20]
        result_d.data   = leftByte - BYTE_ONE;
        result_d.branch = (leftByte != BYTE_ONE);
      end
      OP_SHORTJUMP: result_d.branch = 1'b1;
      // indirect jump target is formed by the fetch logic from result and pointer
      default: result_d.data = leftByte;
    endcase
    if (!legalD) begin
      result_d.branch   = 1'b0;
      result_d.bitWrite = 1'b0;
      result_d.data     = leftByte;
      result_d.carry    = carryFlag;
    end
  end

  // result held until the next instruction is taken
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      result_q <= '0;
    end else if (take) begin
      result_q <= result_d;
    end
  end

  // clock phase inside a machine cycle; stall stretches the cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= 2'h0;
    end else if (take) begin
      phase_q <= 2'h0;
    end else if (busy_q && !cycleStall) begin
      phase_q <= phase_q + 2'h1; // see [RULE21]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mcycle_q <= 2'h0;
    end else if (take) begin
      mcycle_q <= 2'h0;
    end else if (lastClk && mcycle_q != result_q.cycles - CYC_1) begin
      mcycle_q <= mcycle_q + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= lastClk && (mcycle_q == result_q.cycles - CYC_1); // see [RULE21]
      if (take) begin
        busy_q <= 1'b1;
      end else if (lastClk && mcycle_q == result_q.cycles - CYC_1) begin
        busy_q <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  xor_imm_direct_a: assert property (take && op == OP_XOR && dst == ND_DIRECT && src == ND_IMM // see [RULE1]
    |=> result_q.len == LEN_3 && result_q.cycles == CYC_2) else $error("xor imm form not 3/2");
  rotate_carry_a: assert property (take && op == OP_ROTLC && dst == ND_RESULT // see [RULE2]
    |=> result_q.carry == $past(leftByte[7]) && result_q.cycles == CYC_1)
    else $error("rotate through carry wrong");
  into_result_a: assert property (take && op == OP_TRANSFER && dst == ND_RESULT // see [RULE3]
    |=> result_q.cycles == CYC_1) else $error("transfer into result not one cycle");
  bank_direct_a: assert property (take && op == OP_TRANSFER && dst == ND_BANK // see [RULE4]
    && src == ND_DIRECT |=> result_q.len == LEN_2 && result_q.cycles == CYC_2)
    else $error("direct to bank not 2/2");
  direct_direct_a: assert property (take && op == OP_TRANSFER && dst == ND_DIRECT // see [RULE5]
    && src == ND_DIRECT |=> result_q.len == LEN_3 && result_q.cycles == CYC_2)
    else $error("direct to direct not 3/2");
  indirect_acc_a: assert property (take && op == OP_TRANSFER && dst == ND_INDIRECT // see [RULE6]
    && src == ND_RESULT |=> result_q.len == LEN_1 && result_q.cycles == CYC_1)
    else $error("result to indirect not 1/1");
  pointer_load_a: assert property (take && op == OP_TRANSFER && dst == ND_DPOINTER // see [RULE7]
    && src == ND_IMM16 |=> result_q.len == LEN_3) else $error("pointer load not 3 bytes");
  code_read_a: assert property (take && op == OP_CODEREAD && !result_d.illegal // see [RULE8]
    |=> result_q.cycles == CYC_2 && result_q.len == LEN_1) else $error("code read not 1/2");
  ext_move_a: assert property (take && op == OP_EXTMOVE && !result_d.illegal // see [RULE9]
    |=> result_q.cycles == CYC_2) else $error("external move not two cycles");
  stack_op_a: assert property (take && op inside {OP_PUSH, OP_POP} && dst == ND_DIRECT // see [RULE10]
    |=> result_q.len == LEN_2 && result_q.cycles == CYC_2) else $error("stack op not 2/2");
  nibble_swap_a: assert property (take && op == OP_NIBSWAP && !result_d.illegal // see [RULE11]
    |=> result_q.data[3:0] == $past(rightByte[3:0])) else $error("nibble swap low digit wrong");
  bit_carry_a: assert property (take && op == OP_AND && dst == ND_CARRY && src == ND_NBIT // see [RULE12]
    |=> result_q.carry == $past(carryFlag & !testBit)) else $error("and inverted bit wrong");
  carry_to_bit_a: assert property (take && op == OP_TRANSFER && dst == ND_BIT // see [RULE13]
    && src == ND_CARRY |=> result_q.bitWrite && result_q.cycles == CYC_2)
    else $error("carry to bit wrong");
  carry_branch_a: assert property (take && op == OP_BRCARRYCLEAR // see [RULE14]
    |=> result_q.branch == !$past(carryFlag)) else $error("carry clear branch wrong");
  bit_branch_a: assert property (take && op == OP_BRBITSET // see [RULE15]
    |=> result_q.branch == $past(testBit) && result_q.len == LEN_3) else $error("bit branch wrong");
  bit_clear_a: assert property (take && op == OP_BRBITSETCLEAR && testBit // see [RULE16]
    |=> result_q.branch && result_q.bitWrite && !result_q.bitVal) else $error("bit not cleared");
  ind_jump_a: assert property (take && op == OP_INDJUMP // see [RULE17]
    |=> result_q.len == LEN_1 && result_q.cycles == CYC_2) else $error("indirect jump not 1/2");
  zero_branch_a: assert property (take && op == OP_BRZERO // see [RULE18]
    |=> result_q.branch == ($past(leftByte) == BYTE_ZERO)) else $error("zero branch wrong");
  cmp_branch_a: assert property (take && op == OP_CMPBRANCH && !result_d.illegal // see [RULE19]
    |=> result_q.branch == ($past(leftByte) != $past(rightByte))) else $error("compare wrong");
  count_down_a: assert property (take && op == OP_COUNTDOWN && dst == ND_BANK // see [RULE20]
    |=> result_q.data == $past(leftByte) - BYTE_ONE && result_q.len == LEN_2)
    else $error("count down wrong");
  one_cycle_four_a: assert property (take ##1 !cycleStall[*4] |=> // see [RULE21]
    (done_q == (result_q.cycles == CYC_1))) else $error("machine cycle not four clocks");
  stall_hold_a: assert property (busy_q && cycleStall |=> $stable(phase_q) && !done_q) // see [RULE21]
    else $error("stall did not hold phase");
  rel_sign_a: assert property (take && relByte[7] // see [RULE22]
    |=> result_q.offset[15:8] == 8'hFF) else $error("offset not sign extended");
  exits_a: assert property (take && op inside {OP_SUBEXIT, OP_INTEXIT} // see [RULE23]
    |=> result_q.cycles == CYC_2 && result_q.len == LEN_1) else $error("exit not 1/2");
  bit_set_a: assert property (take && op == OP_BITSET && dst == ND_BIT // see [RULE24]
    |=> result_q.len == LEN_2 && result_q.cycles == CYC_1 && result_q.bitVal)
    else $error("bit set wrong");

  two_cycle_c: cover property (take && cycD == CYC_2 ##[1:40] done_q);
  stalled_c:   cover property (busy_q && cycleStall ##[1:20] done_q);
  branch_c:    cover property (take && result_d.branch ##[8:30] done_q);
  illegal_c:   cover property (take && !legalD);

endmodule

`default_nettype wire

// ### milcd_fetch_model.sv
// fetch-side model: presents one instruction at a time, stalls machine cycles
`timescale 1ns/100ps
`default_nettype none
module milcd_fetch_model
  import milcd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        busy_q,
  input  wire logic        reqGo,
  input  wire milcd_insn_t reqInsn,
  input  wire logic [7:0]  reqLeft,
  input  wire logic [7:0]  reqRight,
  input  wire logic [7:0]  reqRel,
  input  wire logic        reqCarry,
  input  wire logic        reqBit,
  input  wire logic        stallEn,
  output var  logic        tookIt,
  output var  logic        insnValid,
  output var  milcd_insn_t insn,
  output var  logic [7:0]  leftByte,
  output var  logic [7:0]  rightByte,
  output var  logic [7:0]  relByte,
  output var  logic        carryFlag,
  output var  logic        testBit,
  output var  logic        cycleStall
);
  logic [7:0] pat;

  // the core takes a request only on an edge where it is idle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tookIt <= 1'b0;
    end else begin
      tookIt <= insnValid && !busy_q;
    end
  end

  always @(negedge clk or negedge nrst) begin
    if (!nrst) begin
      {insnValid, insn, leftByte, rightByte, relByte} = '0;
      {carryFlag, testBit, cycleStall} = 3'h0;
      pat = 8'h5A;
    end else begin
      pat = {pat[6:0], pat[7] ^ pat[5] ^ pat[4] ^ pat[3]};
      cycleStall = stallEn && busy_q && pat[0];
      if (tookIt) begin
        // released operands no longer hold their value
        insnValid = 1'b0;
        {leftByte, rightByte, relByte} = ~{leftByte, rightByte, relByte};
        {carryFlag, testBit} = ~{carryFlag, testBit};
      end else if (reqGo && !insnValid) begin
        insnValid = 1'b1;
        insn = reqInsn;
        {leftByte, rightByte, relByte} = {reqLeft, reqRight, reqRel};
        {carryFlag, testBit} = {reqCarry, reqBit};
      end
    end
  end
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench of the instruction length and cycle decoder
`timescale 1ns/100ps
`default_nettype none
module tb
  import milcd_pkg::*;
;
  // lc holds {len, cycles}: 5=1B/1C 6=1B/2C 9=2B/1C A=2B/2C E=3B/2C
  typedef struct packed {milcd_op_t op; milcd_opnd_t d; milcd_opnd_t s; logic [3:0] lc;} milcd_tv_t;
  localparam int NTV = 73;
  localparam milcd_tv_t TV [NTV] = '{
    '{OP_XOR, ND_RESULT, ND_BANK, 4'h5}, '{OP_XOR, ND_RESULT, ND_DIRECT, 4'h9},
    '{OP_XOR, ND_RESULT, ND_INDIRECT, 4'h5}, '{OP_XOR, ND_RESULT, ND_IMM, 4'h9},
    '{OP_XOR, ND_DIRECT, ND_RESULT, 4'h9}, '{OP_XOR, ND_DIRECT, ND_IMM, 4'hE},
    '{OP_ZERO, ND_RESULT, ND_NONE, 4'h5}, '{OP_INVERT, ND_RESULT, ND_NONE, 4'h5},
    '{OP_ROTL, ND_RESULT, ND_NONE, 4'h5}, '{OP_ROTLC, ND_RESULT, ND_NONE, 4'h5},
    '{OP_ROTR, ND_RESULT, ND_NONE, 4'h5}, '{OP_ROTRC, ND_RESULT, ND_NONE, 4'h5},
    '{OP_ZERO, ND_CARRY, ND_NONE, 4'h5}, '{OP_ZERO, ND_BIT, ND_NONE, 4'h9},
    '{OP_BITSET, ND_CARRY, ND_NONE, 4'h5}, '{OP_BITSET, ND_BIT, ND_NONE, 4'h9},
    '{OP_INVERT, ND_CARRY, ND_NONE, 4'h5}, '{OP_INVERT, ND_BIT, ND_NONE, 4'h9},
    '{OP_TRANSFER, ND_RESULT, ND_BANK, 4'h5}, '{OP_TRANSFER, ND_RESULT, ND_DIRECT, 4'h9},
    '{OP_TRANSFER, ND_RESULT, ND_INDIRECT, 4'h5}, '{OP_TRANSFER, ND_RESULT, ND_IMM, 4'h9},
    '{OP_TRANSFER, ND_BANK, ND_RESULT, 4'h5}, '{OP_TRANSFER, ND_BANK, ND_DIRECT, 4'hA},
    '{OP_TRANSFER, ND_BANK, ND_IMM, 4'h9}, '{OP_TRANSFER, ND_DIRECT, ND_RESULT, 4'h9},
    '{OP_TRANSFER, ND_DIRECT, ND_BANK, 4'hA}, '{OP_TRANSFER, ND_DIRECT, ND_INDIRECT, 4'hA},
    '{OP_TRANSFER, ND_DIRECT, ND_DIRECT, 4'hE}, '{OP_TRANSFER, ND_DIRECT, ND_IMM, 4'hE},
    '{OP_TRANSFER, ND_INDIRECT, ND_RESULT, 4'h5}, '{OP_TRANSFER, ND_INDIRECT, ND_DIRECT, 4'hA},
    '{OP_TRANSFER, ND_INDIRECT, ND_IMM, 4'h9}, '{OP_TRANSFER, ND_DPOINTER, ND_IMM16, 4'hE},
    '{OP_CODEREAD, ND_RESULT, ND_CODEDP, 4'h6}, '{OP_CODEREAD, ND_RESULT, ND_CODEPC, 4'h6},
    '{OP_EXTMOVE, ND_RESULT, ND_EXT8, 4'h6}, '{OP_EXTMOVE, ND_RESULT, ND_EXT16, 4'h6},
    '{OP_EXTMOVE, ND_EXT8, ND_RESULT, 4'h6}, '{OP_EXTMOVE, ND_EXT16, ND_RESULT, 4'h6},
    '{OP_PUSH, ND_DIRECT, ND_NONE, 4'hA}, '{OP_POP, ND_DIRECT, ND_NONE, 4'hA},
    '{OP_SWAPACC, ND_RESULT, ND_BANK, 4'h5}, '{OP_SWAPACC, ND_RESULT, ND_DIRECT, 4'h9},
    '{OP_SWAPACC, ND_RESULT, ND_INDIRECT, 4'h5}, '{OP_NIBSWAP, ND_RESULT, ND_INDIRECT, 4'h5},
    '{OP_AND, ND_CARRY, ND_BIT, 4'hA}, '{OP_AND, ND_CARRY, ND_NBIT, 4'hA},
    '{OP_OR, ND_CARRY, ND_BIT, 4'hA}, '{OP_OR, ND_CARRY, ND_NBIT, 4'hA},
    '{OP_TRANSFER, ND_CARRY, ND_BIT, 4'h9}, '{OP_TRANSFER, ND_BIT, ND_CARRY, 4'hA},
    '{OP_BRCARRYSET, ND_NONE, ND_NONE, 4'hA}, '{OP_BRCARRYCLEAR, ND_NONE, ND_NONE, 4'hA},
    '{OP_BRBITSET, ND_NONE, ND_BIT, 4'hE}, '{OP_BRBITCLEAR, ND_NONE, ND_BIT, 4'hE},
    '{OP_BRBITSETCLEAR, ND_NONE, ND_BIT, 4'hE}, '{OP_INDJUMP, ND_NONE, ND_NONE, 4'h6},
    '{OP_BRZERO, ND_NONE, ND_NONE, 4'hA}, '{OP_BRNONZERO, ND_NONE, ND_NONE, 4'hA},
    '{OP_CMPBRANCH, ND_RESULT, ND_DIRECT, 4'hE}, '{OP_CMPBRANCH, ND_RESULT, ND_IMM, 4'hE},
    '{OP_CMPBRANCH, ND_BANK, ND_IMM, 4'hE}, '{OP_CMPBRANCH, ND_INDIRECT, ND_IMM, 4'hE},
    '{OP_COUNTDOWN, ND_BANK, ND_NONE, 4'hA}, '{OP_COUNTDOWN, ND_DIRECT, ND_NONE, 4'hE},
    '{OP_PAGECALL, ND_NONE, ND_NONE, 4'hA}, '{OP_PAGEJUMP, ND_NONE, ND_NONE, 4'hA},
    '{OP_LONGCALL, ND_NONE, ND_NONE, 4'hE}, '{OP_LONGJUMP, ND_NONE, ND_NONE, 4'hE},
    '{OP_SHORTJUMP, ND_NONE, ND_NONE, 4'hA}, '{OP_SUBEXIT, ND_NONE, ND_NONE, 4'h6},
    '{OP_INTEXIT, ND_NONE, ND_NONE, 4'h6}};

  logic          clk, nrst, reqGo, reqCarry, reqBit, stallEn, tookIt, insnValid;
  logic          carryFlag, testBit, cycleStall, busy_q, done_q;
  milcd_insn_t   reqInsn, insn;
  logic [7:0]    reqLeft, reqRight, reqRel, leftByte, rightByte, relByte;
  logic [1:0]    phase_q, mcycle_q;
  milcd_result_t result_q;
  logic [31:0]   rng;
  int            err_count, n_compared, cycles;

  milcd_core dut_u (.clk(clk), .nrst(nrst), .insnValid(insnValid), .insn(insn),
    .leftByte(leftByte), .rightByte(rightByte), .relByte(relByte), .carryFlag(carryFlag),
    .testBit(testBit), .cycleStall(cycleStall), .busy_q(busy_q), .done_q(done_q),
    .phase_q(phase_q), .mcycle_q(mcycle_q), .result_q(result_q));
  milcd_fetch_model fetch_u (.clk(clk), .nrst(nrst), .busy_q(busy_q), .reqGo(reqGo),
    .reqInsn(reqInsn), .reqLeft(reqLeft), .reqRight(reqRight), .reqRel(reqRel),
    .reqCarry(reqCarry), .reqBit(reqBit), .stallEn(stallEn), .tookIt(tookIt),
    .insnValid(insnValid), .insn(insn), .leftByte(leftByte), .rightByte(rightByte),
    .relByte(relByte), .carryFlag(carryFlag), .testBit(testBit), .cycleStall(cycleStall));

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic test_done;
    $display("mismatches %0d of %0d compares", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // keep leaves the request up so it is offered again while the core is busy
  task automatic run(input milcd_tv_t t, input logic [7:0] l, r, rel, input logic c, b, s, keep);
    int n, st;
    logic chkD, chkC, chkB, cy, br;
    logic [7:0] dd;
    @(negedge clk);
    {reqInsn, reqLeft, reqRight, reqRel, reqCarry, reqBit, stallEn} = {t.op, t.d, t.s, l, r, rel, c, b, s};
    reqGo = 1'b1;
    n = 0;
    while (!tookIt && n < 100) begin
      @(negedge clk);
      n++;
    end
    reqGo = keep;
    {chkD, chkC, chkB, cy, br, dd} = '0;
    case (t.op)
      OP_XOR: {chkD, dd} = {1'b1, l ^ r};
      OP_ZERO: {chkD, dd, chkC, cy} = {t.d == ND_RESULT, BYTE_ZERO, t.d == ND_CARRY, 1'b0};
      OP_INVERT: {chkD, dd, chkC, cy} = {t.d == ND_RESULT, ~l, t.d == ND_CARRY, ~c};
      OP_BITSET: {chkC, cy} = {t.d == ND_CARRY, 1'b1};
      OP_ROTL: {chkD, dd} = {1'b1, l[6:0], l[7]};
      OP_ROTLC: {chkD, dd, chkC, cy} = {1'b1, l[6:0], c, 1'b1, l[7]};
      OP_ROTR: {chkD, dd} = {1'b1, l[0], l[7:1]};
      OP_ROTRC: {chkD, dd, chkC, cy} = {1'b1, c, l[7:1], 1'b1, l[0]};
      OP_AND: {chkC, cy} = {1'b1, c & (t.s == ND_NBIT ? ~b : b)};
      OP_OR: {chkC, cy} = {1'b1, c | (t.s == ND_NBIT ? ~b : b)};
      OP_TRANSFER: {chkD, dd, chkC, cy} = {t.d == ND_RESULT, r, t.d == ND_CARRY, b};
      OP_SWAPACC: {chkD, dd} = {1'b1, r};
      OP_NIBSWAP: {chkD, dd} = {1'b1, l[7:4], r[3:0]};
      OP_BRCARRYSET: {chkB, br} = {1'b1, c};
      OP_BRCARRYCLEAR: {chkB, br} = {1'b1, ~c};
      OP_BRBITSET, OP_BRBITSETCLEAR: {chkB, br} = {1'b1, b};
      OP_BRBITCLEAR: {chkB, br} = {1'b1, ~b};
      OP_BRZERO: {chkB, br} = {1'b1, l == BYTE_ZERO};
      OP_BRNONZERO: {chkB, br} = {1'b1, l != BYTE_ZERO};
      OP_CMPBRANCH: {chkB, br} = {1'b1, l != r};
      OP_COUNTDOWN: {chkD, dd, chkB, br} = {1'b1, l - BYTE_ONE, 1'b1, l != BYTE_ONE};
      OP_SHORTJUMP: {chkB, br} = 2'h3;
      default: {chkB, br} = 2'h2;
    endcase
    chk({result_q.len, result_q.cycles, result_q.illegal}, {t.lc, 1'b0});
    chk(result_q.offset, {{8{rel[7]}}, rel});
    if (chkD) chk(result_q.data, dd);
    if (chkC) chk(result_q.carry, cy);
    if (chkB) chk(result_q.branch, br);
    n = 0;
    st = 0;
    do begin
      @(posedge clk);
      st += int'(cycleStall);
      @(negedge clk);
      n++;
    end while (done_q !== 1'b1 && n < 200);
    // each stalled edge adds a clock
    chk(n, 4 * t.lc[1:0] + st);
    chk({busy_q, phase_q, mcycle_q}, {3'h0, t.lc[1:0] - 2'h1});
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      test_done();
    end
  end

  initial begin
    {nrst, reqGo, reqCarry, reqBit, stallEn, reqInsn, reqLeft, reqRight, reqRel} = '0;
    {err_count, n_compared, cycles} = '0;
    rng = 32'd19;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    // count at its last step, equal compare operands, most negative offset
    for (int i = 0; i < NTV; i++) run(TV[i], 8'h01, 8'h01, 8'h80, 1'b1, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < NTV; i++) run(TV[i], 8'h00, 8'hA5, 8'h7F, 1'b0, 1'b0, 1'b1, 1'b0);
    // offered again while busy: must wait for the done edge
    run(TV[5], 8'h3C, 8'hC3, 8'hFF, 1'b1, 1'b0, 1'b0, 1'b1);
    run(TV[5], 8'h3C, 8'hC3, 8'hFF, 1'b1, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 300; i++) begin
      rng = xs(rng);
      run(TV[rng[31:8] % NTV], rng[7:0], rng[15:8], rng[23:16], rng[24], rng[25], rng[26], 1'b0);
    end
    test_done();
  end
endmodule
`default_nettype wire
